// ===== peripheral_soft_reset_regs.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module peripheral_soft_reset_regs (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Second bus group resets
	output logic serial8_reset_o,
	output logic serial7_reset_o,
	output logic serial6_reset_o,
	output logic twowire3_reset_o,
	output logic clock_calib_reset_o,
	output logic timer11_reset_o,
	output logic timer10_reset_o,
	output logic timer9_reset_o,
	output logic converter3_reset_o,
	output logic sync_serial1_reset_o,
	output logic timer8_reset_o,
	output logic serial_periph1_reset_o,
	output logic timer1_reset_o,
	output logic converter2_reset_o,
	output logic converter1_reset_o,
	output logic port_e_reset_o,
	output logic port_d_reset_o,
	output logic port_c_reset_o,
	output logic port_b_reset_o,
	output logic port_a_reset_o,
	output logic ext_irq_unit_reset_o,
	output logic pin_mux_reset_o,
	// First bus group resets
	output logic dac_block_reset_o,
	output logic power_ctrl_reset_o,
	output logic backup_regs_reset_o,
	output logic can_ctrl2_reset_o,
	output logic can_ctrl1_reset_o,
	output logic usb_block_reset_o,
	output logic twowire2_reset_o,
	output logic twowire1_reset_o,
	output logic serial5_reset_o,
	output logic serial4_reset_o,
	output logic sync_serial3_reset_o,
	output logic sync_serial2_reset_o,
	output logic serial_periph4_reset_o,
	output logic serial_periph3_reset_o,
	output logic serial_periph2_reset_o,
	output logic window_watchdog_reset_o,
	output logic [8:0] bus1_timer_resets_o
);

	periph_reset_pkg::reset_bank_state_t state;
	periph_reset_pkg::reset_bank_state_t next_state;
	// Register hits of the current access, one-hot
	logic hit_bus2;
	logic hit_bus1;

	// Address decode shared by the write and the read path, so both always agree on which
	// word an offset names; any other offset selects nothing
	function automatic logic [1:0] decode_reg(input logic [7:0] addr);
		logic [1:0] sel;
		sel = 2'h0;
		case (addr)
			periph_reset_pkg::BUS2_RST_OFS: begin
				sel = 2'h1;
			end
			periph_reset_pkg::BUS1_RST_OFS: begin
				sel = 2'h2;
			end
			default: begin
				sel = 2'h0;
			end
		endcase
		return sel;
	endfunction : decode_reg

	// Read-back view of a control word: reserved positions are already zero in the store,
	// bits that must read as zero are hidden here without touching their reset line
	function automatic logic [31:0] read_view(input logic [31:0] value, input logic [31:0] rzero);
		return value & ~rzero;
	endfunction : read_view

	// One decode per access; the master never raises both strobes together
	assign {hit_bus1, hit_bus2} = decode_reg(reg_addr_i);

	// Next state: masked writes, read data captured for the following cycle
	always_comb begin
		next_state = state;
		// Read data stands one cycle only, zero whenever no read was taken
		next_state.rdata = 32'h0000_0000;
		if (reg_wr_i && hit_bus2) begin
			// Reserved positions never take a one
			next_state.bus2_periph_reset_ctrl =
				reg_wdata_i & periph_reset_pkg::BUS2_RST_WMASK;
		end
		if (reg_wr_i && hit_bus1) begin
			// Backup register line sits in this word like any other writable bit
			next_state.bus1_periph_reset_ctrl =
				reg_wdata_i & periph_reset_pkg::BUS1_RST_WMASK;
		end
		// Unmapped writes fall through both tests and are dropped
		if (reg_rd_i && hit_bus2) begin
			// Interrupt unit bit still drives its reset, only hidden
			next_state.rdata = read_view(state.bus2_periph_reset_ctrl,
				periph_reset_pkg::BUS2_RST_RZERO);
		end
		if (reg_rd_i && hit_bus1) begin
			next_state.rdata = read_view(state.bus1_periph_reset_ctrl,
				periph_reset_pkg::BUS1_RST_RZERO);
		end
		// Unmapped reads leave the zero default in place
	end

	// State register; system reset clears every control bit
	// The reset is synchronous, so a peripheral released by it leaves reset on a clock edge
	// and never glitches between edges
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state.bus2_periph_reset_ctrl <= periph_reset_pkg::BUS2_RST_RESET;
			state.bus1_periph_reset_ctrl <= periph_reset_pkg::BUS1_RST_RESET;
			state.rdata <= 32'h0000_0000;
		end else begin
			state <= next_state;
		end
	end

	// Read data straight from its flop, zero outside the answering cycle
	assign reg_rdata_o = state.rdata;

	// Reset lines are plain levels of the control bits, so a peripheral stays
	// held for exactly as long as software leaves its bit at one
	assign serial8_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::SERIAL8_POS];
	assign serial7_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::SERIAL7_POS];
	assign serial6_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::SERIAL6_POS];

	// Two-wire port and clock calibration unit
	assign twowire3_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::TWOWIRE3_POS];
	assign clock_calib_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::CLOCK_CALIB_POS];

	// Timers of the upper group
	assign timer11_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::TIMER11_POS];
	assign timer10_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::TIMER10_POS];
	assign timer9_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::TIMER9_POS];

	// Converter 3 sits just below the reserved gap, which has no lines
	assign converter3_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::CONVERTER3_POS];

	// Synchronous serial port and the second advanced timer
	assign sync_serial1_reset_o =
		state.bus2_periph_reset_ctrl[periph_reset_pkg::SYNC_SERIAL1_POS];
	assign timer8_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::TIMER8_POS];

	// Serial peripheral port and the first advanced timer
	assign serial_periph1_reset_o =
		state.bus2_periph_reset_ctrl[periph_reset_pkg::SERIAL_PERIPH1_POS];
	assign timer1_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::TIMER1_POS];

	// Converters 1 and 2
	assign converter2_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::CONVERTER2_POS];
	assign converter1_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::CONVERTER1_POS];

	// General purpose ports; the reserved pair above them has no lines
	assign port_e_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::PORT_E_POS];
	assign port_d_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::PORT_D_POS];
	assign port_c_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::PORT_C_POS];
	assign port_b_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::PORT_B_POS];
	assign port_a_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::PORT_A_POS];

	// Interrupt unit line follows its bit even though reads hide it
	assign ext_irq_unit_reset_o =
		state.bus2_periph_reset_ctrl[periph_reset_pkg::EXT_IRQ_UNIT_POS];
	assign pin_mux_reset_o = state.bus2_periph_reset_ctrl[periph_reset_pkg::PIN_MUX_POS];

	// First bus group lines, same level behaviour
	assign dac_block_reset_o = state.bus1_periph_reset_ctrl[periph_reset_pkg::DAC_BLOCK_POS];
	assign power_ctrl_reset_o = state.bus1_periph_reset_ctrl[periph_reset_pkg::POWER_CTRL_POS];

	// Battery-backed registers stay cleared while the bit is one; software writes zero again
	assign backup_regs_reset_o =
		state.bus1_periph_reset_ctrl[periph_reset_pkg::BACKUP_REGS_POS];

	// CAN controllers; the bit below them is reserved
	assign can_ctrl2_reset_o = state.bus1_periph_reset_ctrl[periph_reset_pkg::CAN_CTRL2_POS];
	assign can_ctrl1_reset_o = state.bus1_periph_reset_ctrl[periph_reset_pkg::CAN_CTRL1_POS];

	// USB block and two-wire ports
	assign usb_block_reset_o = state.bus1_periph_reset_ctrl[periph_reset_pkg::USB_BLOCK_POS];
	assign twowire2_reset_o = state.bus1_periph_reset_ctrl[periph_reset_pkg::TWOWIRE2_POS];
	assign twowire1_reset_o = state.bus1_periph_reset_ctrl[periph_reset_pkg::TWOWIRE1_POS];

	// Plain serial ports 4 and 5
	assign serial5_reset_o = state.bus1_periph_reset_ctrl[periph_reset_pkg::SERIAL5_POS];
	assign serial4_reset_o = state.bus1_periph_reset_ctrl[periph_reset_pkg::SERIAL4_POS];

	// Synchronous serial ports 2 and 3
	assign sync_serial3_reset_o =
		state.bus1_periph_reset_ctrl[periph_reset_pkg::SYNC_SERIAL3_POS];
	assign sync_serial2_reset_o =
		state.bus1_periph_reset_ctrl[periph_reset_pkg::SYNC_SERIAL2_POS];

	// Serial peripheral ports 2 to 4
	assign serial_periph4_reset_o =
		state.bus1_periph_reset_ctrl[periph_reset_pkg::SERIAL_PERIPH4_POS];
	assign serial_periph3_reset_o =
		state.bus1_periph_reset_ctrl[periph_reset_pkg::SERIAL_PERIPH3_POS];
	assign serial_periph2_reset_o =
		state.bus1_periph_reset_ctrl[periph_reset_pkg::SERIAL_PERIPH2_POS];

	// Window watchdog; the two bits above it are reserved
	assign window_watchdog_reset_o =
		state.bus1_periph_reset_ctrl[periph_reset_pkg::WINDOW_WATCHDOG_POS];
	// Low timer group, one line per bit; the loop keeps each line at its own bit
	// so a change of the group's top bit needs no edit here
	for (genvar t = 0; t <= periph_reset_pkg::BUS1_TIMERS_MSB; t = t + 1) begin : g_bus1_timer
		assign bus1_timer_resets_o[t] = state.bus1_periph_reset_ctrl[t];
	end

endmodule : peripheral_soft_reset_regs
`default_nettype wire

// ===== periph_reset_pkg.sv
`default_nettype none
package periph_reset_pkg;
	// Register word offsets (byte addresses)
	localparam logic [7:0] BUS2_RST_OFS = 8'h00;
	localparam logic [7:0] BUS1_RST_OFS = 8'h04;
	// Reset values of both control registers
	localparam logic [31:0] BUS2_RST_RESET = 32'h0000_0000;
	localparam logic [31:0] BUS1_RST_RESET = 32'h0000_0000;
	// Writable bits; every other bit is reserved and stays zero
	localparam logic [31:0] BUS2_RST_WMASK = 32'h07F8_FE7F;
	localparam logic [31:0] BUS1_RST_WMASK = 32'h3EFF_C9FF;
	// Bits that hold state but always read back as zero
	localparam logic [31:0] BUS2_RST_RZERO = 32'h0000_0002;
	localparam logic [31:0] BUS1_RST_RZERO = 32'h0000_0000;
	// Second bus group field positions
	localparam int SERIAL8_POS = 26;
	localparam int SERIAL7_POS = 25;
	localparam int SERIAL6_POS = 24;
	localparam int TWOWIRE3_POS = 23;
	localparam int CLOCK_CALIB_POS = 22;
	localparam int TIMER11_POS = 21;
	localparam int TIMER10_POS = 20;
	localparam int TIMER9_POS = 19;
	localparam int CONVERTER3_POS = 15;
	localparam int SYNC_SERIAL1_POS = 14;
	localparam int TIMER8_POS = 13;
	localparam int SERIAL_PERIPH1_POS = 12;
	localparam int TIMER1_POS = 11;
	localparam int CONVERTER2_POS = 10;
	localparam int CONVERTER1_POS = 9;
	localparam int PORT_E_POS = 6;
	localparam int PORT_D_POS = 5;
	localparam int PORT_C_POS = 4;
	localparam int PORT_B_POS = 3;
	localparam int PORT_A_POS = 2;
	localparam int EXT_IRQ_UNIT_POS = 1;
	localparam int PIN_MUX_POS = 0;
	// First bus group field positions
	localparam int DAC_BLOCK_POS = 29;
	localparam int POWER_CTRL_POS = 28;
	localparam int BACKUP_REGS_POS = 27;
	localparam int CAN_CTRL2_POS = 26;
	localparam int CAN_CTRL1_POS = 25;
	localparam int USB_BLOCK_POS = 23;
	localparam int TWOWIRE2_POS = 22;
	localparam int TWOWIRE1_POS = 21;
	localparam int SERIAL5_POS = 20;
	localparam int SERIAL4_POS = 19;
	localparam int SYNC_SERIAL3_POS = 18;
	localparam int SYNC_SERIAL2_POS = 17;
	localparam int SERIAL_PERIPH4_POS = 16;
	localparam int SERIAL_PERIPH3_POS = 15;
	localparam int SERIAL_PERIPH2_POS = 14;
	localparam int WINDOW_WATCHDOG_POS = 11;
	localparam int BUS1_TIMERS_MSB = 8;
	// Whole state of the reset bank
	typedef struct packed {
		logic [31:0] bus2_periph_reset_ctrl;
		logic [31:0] bus1_periph_reset_ctrl;
		logic [31:0] rdata;
	} reset_bank_state_t;
endpackage : periph_reset_pkg
`default_nettype wire

// ===== peripheral_soft_reset_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module soft_reset_checker (
	// Clock, reset and register port
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	// Sampled reset lines
	input wire logic port_a_reset_o,
	input wire logic ext_irq_unit_reset_o,
	input wire logic backup_regs_reset_o,
	input wire logic window_watchdog_reset_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	// Strobes decoded per register once, so each property stays short
	wire wr2 = reg_wr_i && reg_addr_i == periph_reset_pkg::BUS2_RST_OFS;
	wire wr1 = reg_wr_i && reg_addr_i == periph_reset_pkg::BUS1_RST_OFS;
	wire rd2 = reg_rd_i && reg_addr_i == periph_reset_pkg::BUS2_RST_OFS;
	wire rd1 = reg_rd_i && reg_addr_i == periph_reset_pkg::BUS1_RST_OFS;
	// Bits that may ever read back as one
	wire [31:0] seen2 = periph_reset_pkg::BUS2_RST_WMASK & ~periph_reset_pkg::BUS2_RST_RZERO;
	wire [31:0] seen1 = periph_reset_pkg::BUS1_RST_WMASK & ~periph_reset_pkg::BUS1_RST_RZERO;
	a_rsvd_bus2: assert property (
		rd2 |=> (reg_rdata_o & ~seen2) == 32'h0000_0000)
		else $error("bus2 read shows reserved or read-zero bit");
	a_rsvd_bus1: assert property (
		rd1 |=> (reg_rdata_o & ~seen1) == 32'h0000_0000)
		else $error("bus1 read shows reserved bit");
	a_read_tracks: assert property (
		rd2 |=> reg_rdata_o[2] == port_a_reset_o)
		else $error("read data differs from reset line");
	a_porta_write: assert property (
		wr2 |=> port_a_reset_o == $past(reg_wdata_i[2]))
		else $error("port a line did not follow write");
	a_extirq_write: assert property (
		wr2 |=> ext_irq_unit_reset_o == $past(reg_wdata_i[1]))
		else $error("ext irq line did not follow write");
	a_backup_write: assert property (
		wr1 |=> backup_regs_reset_o == $past(reg_wdata_i[27]))
		else $error("backup line did not follow write");
	a_wdog_write: assert property (
		wr1 |=> window_watchdog_reset_o == $past(reg_wdata_i[11]))
		else $error("watchdog line did not follow write");
	// A system reset sampled high clears the lines, so it is no hold case
	a_line_holds: assert property (
		!reg_wr_i && !srst_i |=> $stable(port_a_reset_o) && $stable(backup_regs_reset_o))
		else $error("reset line moved without a write");
	a_reset_clear: assert property (
		disable iff (1'b0) srst_i |=> !port_a_reset_o && !backup_regs_reset_o)
		else $error("lines not cleared by system reset");
	// Main scenarios reached
	c_backup: cover property (wr1 && reg_wdata_i[27]);
	c_read2: cover property (wr2 ##2 rd2);
	c_extirq: cover property (ext_irq_unit_reset_o && rd2);
endmodule : soft_reset_checker
bind peripheral_soft_reset_regs soft_reset_checker u_chk (.sys_clk_i, .srst_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .port_a_reset_o, .ext_irq_unit_reset_o,
	.backup_regs_reset_o, .window_watchdog_reset_o);
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [31:0] M2 = periph_reset_pkg::BUS2_RST_WMASK;
	localparam logic [31:0] M1 = periph_reset_pkg::BUS1_RST_WMASK;
	localparam logic [31:0] RZ2 = periph_reset_pkg::BUS2_RST_RZERO;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	// Reset lines gathered at their register positions; reserved positions are tied low
	wire [31:0] o2;
	wire [31:0] o1;
	assign o2[31:27] = 5'h00;
	assign o2[18:16] = 3'h0;
	assign o2[8:7] = 2'h0;
	assign o1[31:30] = 2'h0;
	assign o1[24] = 1'h0;
	assign o1[13:12] = 2'h0;
	assign o1[10:9] = 2'h0;
	int bad_count = 0;
	int tests_run = 0;
	peripheral_soft_reset_regs dut (.sys_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .serial8_reset_o(o2[26]), .serial7_reset_o(o2[25]),
		.serial6_reset_o(o2[24]), .twowire3_reset_o(o2[23]), .clock_calib_reset_o(o2[22]),
		.timer11_reset_o(o2[21]), .timer10_reset_o(o2[20]), .timer9_reset_o(o2[19]),
		.converter3_reset_o(o2[15]), .sync_serial1_reset_o(o2[14]), .timer8_reset_o(o2[13]),
		.serial_periph1_reset_o(o2[12]), .timer1_reset_o(o2[11]), .converter2_reset_o(o2[10]),
		.converter1_reset_o(o2[9]), .port_e_reset_o(o2[6]), .port_d_reset_o(o2[5]),
		.port_c_reset_o(o2[4]), .port_b_reset_o(o2[3]), .port_a_reset_o(o2[2]),
		.ext_irq_unit_reset_o(o2[1]), .pin_mux_reset_o(o2[0]), .dac_block_reset_o(o1[29]),
		.power_ctrl_reset_o(o1[28]), .backup_regs_reset_o(o1[27]), .can_ctrl2_reset_o(o1[26]),
		.can_ctrl1_reset_o(o1[25]), .usb_block_reset_o(o1[23]), .twowire2_reset_o(o1[22]),
		.twowire1_reset_o(o1[21]), .serial5_reset_o(o1[20]), .serial4_reset_o(o1[19]),
		.sync_serial3_reset_o(o1[18]), .sync_serial2_reset_o(o1[17]),
		.serial_periph4_reset_o(o1[16]), .serial_periph3_reset_o(o1[15]),
		.serial_periph2_reset_o(o1[14]), .window_watchdog_reset_o(o1[11]),
		.bus1_timer_resets_o(o1[8:0]));
	// Free-running system clock
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask : chk
	// One-cycle strobes; data is judged a step after the edge so updates have landed
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask : rd
	task automatic t_fill(input logic [31:0] d);
		wr(8'h00, d);
		wr(8'h04, d);
		chk(o2 & M2, d & M2);
		chk(o1 & M1, d & M1);
		rd(8'h00, d & M2 & ~RZ2);
		rd(8'h04, d & M1);
	endtask : t_fill
	// Unmapped write must leave every line alone and read as zero
	task automatic t_unmapped;
		t_fill(32'h0000_0004);
		wr(8'h08, 32'hFFFF_FFFF);
		chk(o2 & M2, 32'h0000_0004);
		chk(o1 & M1, 32'h0000_0004);
		rd(8'h08, 32'h0000_0000);
	endtask : t_unmapped
	task automatic t_rst;
		t_fill(32'hFFFF_FFFF);
		@(posedge sys_clk_i);
		srst_i <= 1'b1;
		@(posedge sys_clk_i);
		srst_i <= 1'b0;
		#1 chk(o2 & M2, 32'h0000_0000);
		chk(o1 & M1, 32'h0000_0000);
		rd(8'h04, 32'h0000_0000);
	endtask : t_rst
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	// Whole run is well under a thousand cycles
	initial begin
		#20000;
		bad_count++;
		end_sim;
	end
	initial begin
		repeat (5) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		rd(8'h00, 32'h0000_0000);
		rd(8'h04, 32'h0000_0000);
		t_fill(32'hFFFF_FFFF);
		t_fill(32'h0000_0000);
		t_fill(32'hAAAA_AAAA);
		t_fill(32'h0800_0002);
		t_fill(32'hF807_0180);
		t_unmapped;
		t_rst;
		end_sim;
	end
endmodule : tb_top
`default_nettype wire
